// file: hdl/dsps_pkg.sv
package dsps_pkg;

	// ==========================================
	// Phase codes on the two select pins {first, second}
	typedef enum logic [1:0]
	{
		integrator_clear_phase = 2'h0,
		offset_null_phase = 2'h1,
		integrate_phase = 2'h2,
		reference_rampdown_phase = 2'h3
	} phase_code_t;

	// ==========================================
	// Widths and default timing counts
	localparam int COUNT_W = 24;
	localparam int CHAN_W = 2;
	localparam logic [23:0] INT_CYCLES_DEF = 24'h00_1000;
	localparam logic [23:0] DEINT_MAX_DEF = 24'h00_2000;
	localparam logic [23:0] CLEAR_MAX_DEF = 24'h00_1000;
	localparam logic [23:0] COUNT_ZERO = 24'h00_0000;
	localparam logic [23:0] COUNT_ONE = 24'h00_0001;
	localparam int CLK_MHZ = 250;
	localparam int CMP_DELAY_NS = 2000;
	localparam int CMP_DELAY_CYCLES = (CMP_DELAY_NS * CLK_MHZ) / 1000;
	localparam logic [1:0] SIGN_LEAD_CYCLES = 2'h1;

	// ==========================================
	// Conversion result
	typedef struct packed
	{
		logic sign_positive;
		logic overrange;
		logic [23:0] magnitude;
		logic [1:0] channel;
	} result_t;

	// ==========================================
	// Pins toward the front end
	typedef struct packed
	{
		logic phase_first;
		logic phase_second;
		logic chan_select_msb;
		logic chan_select_lsb;
	} fe_pins_t;

endpackage

// file: hdl/pin_sync.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Two-flop synchroniser for the comparator pin
module pin_sync
(
	// Clocking
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Data
	input wire logic async_in,
	output logic sync_out
);
	logic meta_r;
	logic sync_r;

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
		end
		else if (clk_en)
		begin
			meta_r <= async_in;
			sync_r <= meta_r;
		end
	end

	assign sync_out = sync_r;
endmodule
`default_nettype wire

// file: hdl/phase_timer.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Clearable up-counter shared by all timed phases
module phase_timer #(
	parameter int W = 24
)
(
	// Clocking
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// Control
	input wire logic clear,
	input wire logic run,
	// Count
	output logic [W-1:0] count
);
	logic [W-1:0] count_r;
	logic [W-1:0] count_nxt;

	assign count_nxt = clear ? '0 : (run ? count_r + W'(1) : count_r);

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			count_r <= '0;
		else if (clk_en)
			count_r <= count_nxt;
	end

	assign count = count_r;
endmodule
`default_nettype wire

// file: hdl/dual_slope_phase_sequencer.sv
// How it works
// (RL1) We drive both phase pins, watch comparator
// (RL2) Integration length fixed by one parameter
// (RL3) Sign sampled late in integration only
// (RL4) Integration ends by code 10 to 11
// (RL5) Count from 11 to comparator fall
// (RL6) Comparator lags about two microseconds
// (RL7) Comparator level polled during rampdown
// (RL8) Code 00 held until comparator high
// (RL9) Leave clear phase on first high
// (RL10) Then code 01 until next start
// (RL11) Offset null is the unlimited idle
// (RL12) Offset null as long as integration
// (RL13) Channel select 00 is channel zero
// (RL14) Pin pair maps to four phases
// (RL15) Comparator high positive, falls at zero
// (RL16) Comparator ignored during offset null
// (RL17) Both pins change on one edge
// (RL18) Timeouts flag overrange, return to idle
`timescale 1ns/10ps
`default_nettype none
module dual_slope_phase_sequencer #(
	parameter int COUNT_W = dsps_pkg::COUNT_W,
	parameter logic [23:0] INT_CYCLES = dsps_pkg::INT_CYCLES_DEF,
	parameter logic [23:0] DEINT_MAX = dsps_pkg::DEINT_MAX_DEF,
	parameter logic [23:0] CLEAR_MAX = dsps_pkg::CLEAR_MAX_DEF
)
(
	// Clocking
	input wire logic sys_clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// User request
	input wire logic start,
	input wire logic [1:0] channel_req,
	output logic busy,
	// User result
	output logic result_valid,
	output dsps_pkg::result_t result,
	// Front end pins
	output dsps_pkg::fe_pins_t fe_pins,
	input wire logic zero_cross_out
);

	// ==========================================
	// Sequencer states
	typedef enum logic [2:0]
	{
		st_idle,
		st_null,
		st_integrate,
		st_rampdown,
		st_clear
	} seq_state_t;

	seq_state_t state_r;
	seq_state_t state_nxt;
	logic cmp_sync;
	logic cmp_prev_r;
	logic [23:0] count;
	logic timer_clear;
	logic null_done;
	logic int_done;
	logic sign_window;
	logic cmp_fell;
	logic deint_timeout;
	logic clear_timeout;
	logic start_taken;
	logic sign_take;
	logic ramp_end;
	logic clear_stuck;
	logic clear_end;
	logic [1:0] phase_nxt;
	logic [1:0] phase_r;
	logic [1:0] chan_sel_r;
	logic sign_r;
	logic overrange_r;
	logic [23:0] mag_r;
	logic [1:0] chan_r;
	logic result_valid_r;
	logic busy_r;

	// ==========================================
	// Comparator input and shared timer
	pin_sync u_cmp_sync
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.async_in(zero_cross_out),
		.sync_out(cmp_sync)
	);

	phase_timer #(
		.W(24)
	) u_timer
	(
		.sys_clk(sys_clk),
		.reset_n(reset_n),
		.clk_en(clk_en),
		.clear(timer_clear),
		.run(1'b1),
		.count(count)
	);

	// ==========================================
	// Phase decisions
	// Offset null matches integration; length comes from the same constant
	assign null_done = (count >= INT_CYCLES - dsps_pkg::COUNT_ONE); // RL12
	assign int_done = (count >= INT_CYCLES - dsps_pkg::COUNT_ONE); // RL2
	// Sign taken in the last cycle only, early readings are noisy
	assign sign_window = int_done; // RL3
	// Falling edge seen on the synchronised level, polled each cycle
	assign cmp_fell = cmp_prev_r & ~cmp_sync; // RL7 RL15
	assign deint_timeout = (count >= DEINT_MAX - dsps_pkg::COUNT_ONE); // RL18
	assign clear_timeout = (count >= CLEAR_MAX - dsps_pkg::COUNT_ONE); // RL18
	assign start_taken = (state_r == st_idle) && start;
	assign sign_take = (state_r == st_integrate) && sign_window; // RL3
	assign ramp_end = (state_r == st_rampdown) && (cmp_fell || deint_timeout); // RL5 RL18
	assign clear_stuck = (state_r == st_clear) && clear_timeout && !cmp_sync; // RL18
	assign clear_end = (state_r == st_clear) && (state_nxt == st_idle); // RL9

	always_comb
	begin
		state_nxt = state_r;
		timer_clear = 1'b0;
		case (state_r)
			st_idle:
			begin
				timer_clear = 1'b1;
				if (start)
					state_nxt = st_null;
			end
			st_null:
			begin
				// Comparator has no meaning here and is not looked at
				if (null_done) // RL16
				begin
					state_nxt = st_integrate;
					timer_clear = 1'b1;
				end
			end
			st_integrate:
			begin
				if (int_done) // RL4
				begin
					state_nxt = st_rampdown;
					timer_clear = 1'b1;
				end
			end
			st_rampdown:
			begin
				if (cmp_fell || deint_timeout) // RL5 RL18
				begin
					state_nxt = st_clear;
					timer_clear = 1'b1;
				end
			end
			st_clear:
			begin
				if (cmp_sync || clear_timeout) // RL8 RL9
					state_nxt = st_idle;
			end
			default:
				state_nxt = st_idle;
		endcase
	end

	// ==========================================
	// Phase code for the next state, registered so both pins move together
	assign phase_nxt = (state_nxt == st_integrate) ? dsps_pkg::integrate_phase :
		(state_nxt == st_rampdown) ? dsps_pkg::reference_rampdown_phase :
		(state_nxt == st_clear) ? dsps_pkg::integrator_clear_phase :
		dsps_pkg::offset_null_phase; // RL10 RL11 RL14

	// ==========================================
	// Sequencer registers
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			state_r <= st_idle;
		else if (clk_en)
			state_r <= state_nxt;
	end

	// Resets low like the synchroniser, so reset never fakes a fall
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			cmp_prev_r <= 1'b0;
		else if (clk_en)
			cmp_prev_r <= cmp_sync; // RL7
	end

	// ==========================================
	// Front end pins
	// Both phase bits come from one register, so no stray code can appear
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			phase_r <= dsps_pkg::offset_null_phase; // RL11
		else if (clk_en)
			phase_r <= phase_nxt; // RL17 RL1
	end

	// Select moves as offset null begins, so the mux settles during that phase
	// and never changes while the input is being integrated
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			chan_sel_r <= 2'h0;
		else if (clk_en && start_taken)
			chan_sel_r <= channel_req; // RL13
	end

	// ==========================================
	// Result capture
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			sign_r <= 1'b0;
		else if (clk_en && sign_take)
			sign_r <= cmp_sync; // RL3
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			overrange_r <= 1'b0;
		else if (clk_en)
		begin
			if (start_taken)
				overrange_r <= 1'b0;
			else if (ramp_end)
				overrange_r <= deint_timeout & ~cmp_fell; // RL18
			else if (clear_stuck)
				overrange_r <= 1'b1; // RL18
		end
	end

	// Count includes the comparator and synchroniser lag; see CMP_DELAY_CYCLES
	// The lag is left in so software can subtract its own calibrated figure
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			mag_r <= dsps_pkg::COUNT_ZERO;
		else if (clk_en && ramp_end)
			mag_r <= count + dsps_pkg::COUNT_ONE; // RL5 RL6
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			chan_r <= 2'h0;
		else if (clk_en && start_taken)
			chan_r <= channel_req;
	end

	// ==========================================
	// Status flags
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			result_valid_r <= 1'b0;
		else if (clk_en)
			result_valid_r <= clear_end; // RL10
	end

	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			busy_r <= 1'b0;
		else if (clk_en)
			busy_r <= (state_nxt != st_idle);
	end

	// ==========================================
	// Outputs, each straight from a register
	assign busy = busy_r;
	assign result_valid = result_valid_r;
	assign result = '{sign_r, overrange_r, mag_r, chan_r};
	assign fe_pins = '{phase_r[1], phase_r[0], chan_sel_r[1], chan_sel_r[0]}; // RL14
endmodule
`default_nettype wire

// file: verif/fe_model.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Front end comparator as seen from the pins
module fe_model
(
	// Clock and scenario knobs
	input wire logic sys_clk,
	input wire logic sign_in,
	input wire logic stuck,
	input wire logic [7:0] ramp,
	// Pins
	input wire dsps_pkg::fe_pins_t fe_pins,
	output logic zero_cross_out
);
	wire logic [1:0] ph = {fe_pins.phase_first, fe_pins.phase_second};
	logic [1:0] ph_r = 2'h1;
	logic [7:0] cnt_r = 8'h00;
	// Age of the phase at this edge; a new phase starts from zero, never a stale count
	wire logic [7:0] run = (ph == ph_r) ? cnt_r + 8'h01 : 8'h00;
	initial zero_cross_out = 1'b0;
	// Ramp count folds in the comparator lag; early integrate readings are wrong
	always @(posedge sys_clk)
	begin
		ph_r <= ph;
		cnt_r <= run;
		case (ph)
			2'h1: zero_cross_out <= ~zero_cross_out;
			2'h2: zero_cross_out <= (run < 8'h02) ^ sign_in;
			2'h3: zero_cross_out <= stuck || run < ramp;
			default: zero_cross_out <= !stuck && run > 8'h02;
		endcase
	end
endmodule
`default_nettype wire

// file: verif/dsps_chk.sv
`timescale 1ns/10ps
`default_nettype none
// ==========================================
// Phase order and timing checker
module dsps_chk #(parameter logic [23:0] INT_CYCLES = dsps_pkg::INT_CYCLES_DEF)
(
	// Clocking
	input wire logic sys_clk,
	input wire logic reset_n,
	// User side
	input wire logic start,
	input wire logic busy,
	input wire logic result_valid,
	input wire dsps_pkg::result_t result,
	// Front end
	input wire dsps_pkg::fe_pins_t fe_pins,
	input wire logic zero_cross_out
);
	wire logic [1:0] ph = {fe_pins.phase_first, fe_pins.phase_second};
	logic [1:0] ph_r;
	logic [23:0] len_r;
	// Run length of the current phase
	always_ff @(posedge sys_clk or negedge reset_n)
		if (!reset_n)
		begin
			ph_r <= 2'h1;
			len_r <= 24'h00_0000;
		end
		else
		begin
			ph_r <= ph;
			len_r <= (ph == ph_r) ? len_r + 24'h00_0001 : 24'h00_0001;
		end
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	chk_phase_step: assert property (ph != ph_r |-> {ph_r, ph} inside {4'h6, 4'hB, 4'hC, 4'h1, 4'hD})
		else $error("phase step out of order");
	chk_idle_null: assert property (!busy |-> ph == 2'h1)
		else $error("idle not offset null");
	chk_start_busy: assert property (start && !busy && !result_valid |=> busy)
		else $error("start not taken");
	chk_int_len: assert property (ph_r == 2'h2 && ph == 2'h3 |-> len_r == INT_CYCLES)
		else $error("integration length wrong");
	chk_ramp_exit: assert property (ph == 2'h3 && $fell(zero_cross_out) |-> ##[2:4] ph == 2'h0)
		else $error("rampdown not ended");
	chk_clear_exit: assert property (ph == 2'h0 && $rose(zero_cross_out) |-> ##[2:4] ph == 2'h1)
		else $error("clear phase left late");
	chk_clear_hold: assert property (ph_r == 2'h0 && ph == 2'h1 |-> result_valid && ($past(zero_cross_out, 2) || result.overrange))
		else $error("clear phase left early");
	chk_done_pulse: assert property (result_valid |-> !busy ##1 !result_valid)
		else $error("done pulse wrong");
	cover property (result_valid && result.overrange);
	cover property (result_valid && !result.sign_positive);
	cover property (ph_r == 2'h3 && ph == 2'h0);
endmodule
bind dual_slope_phase_sequencer dsps_chk #(.INT_CYCLES(INT_CYCLES)) chk_i
	(.sys_clk, .reset_n, .start, .busy, .result_valid, .result, .fe_pins, .zero_cross_out);
`default_nettype wire

// file: verif/dual_slope_phase_sequencer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD %s exp %0h got %0h", n, e, g); end end
module dual_slope_phase_sequencer_tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic start = 1'b0, sg = 1'b0, stk = 1'b0, ce = 1'b1;
	logic [1:0] channel_req = 2'h0;
	logic [7:0] rp = 8'h10;
	logic busy, result_valid, zero_cross_out;
	dsps_pkg::result_t result;
	dsps_pkg::fe_pins_t fe_pins;
	int mismatches = 0, checked = 0;
	always #2 sys_clk = ~sys_clk;
	dual_slope_phase_sequencer #(.INT_CYCLES(24'h00_0008), .DEINT_MAX(24'h00_0040),
		.CLEAR_MAX(24'h00_0040)) DUT (.sys_clk, .reset_n, .clk_en(ce), .start,
		.channel_req, .busy, .result_valid, .result, .fe_pins, .zero_cross_out);
	fe_model fe_i (.sys_clk, .sign_in(sg), .stuck(stk), .ramp(rp), .fe_pins, .zero_cross_out);
	task automatic finish_test;
		if (mismatches == 0 && checked > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	// Bounded so a lost done pulse cannot stall the run
	// First look is one edge on, so a pulse still standing from the last run is not taken
	task automatic wait_done;
		@(posedge sys_clk) #1;
		for (int k = 0; k < 400 && result_valid !== 1'b1; k++)
			@(posedge sys_clk) #1;
		`CHK("done", 1'b1, result_valid)
	endtask
	task automatic conv(input logic [1:0] ch, input logic s, input logic [7:0] r, input logic t);
		@(posedge sys_clk);
		channel_req <= ch;
		sg <= s;
		rp <= r;
		stk <= t;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		wait_done();
		`CHK("over", t, result.overrange)
		`CHK("chan", ch, result.channel)
		`CHK("mux", ch, {fe_pins.chan_select_msb, fe_pins.chan_select_lsb})
		if (!t)
		begin
			`CHK("sign", s, result.sign_positive)
			`CHK("mag", 1'b1, result.magnitude - 24'(r) < 24'h00_0007)
		end
		`CHK("idle", 2'h1, {fe_pins.phase_first, fe_pins.phase_second})
	endtask
	// Every channel code, both signs, and a comparator that never crosses
	task automatic t_table;
		for (int i = 0; i < 5; i++)
			conv(2'(i), i[0], 8'h10 + 8'(i), i == 4);
	endtask
	// Start held high: refused while busy, taken again right after done
	task automatic t_b2b;
		@(posedge sys_clk);
		start <= 1'b1;
		wait_done();
		@(posedge sys_clk) #1;
		`CHK("rearm", 1'b1, busy)
		@(posedge sys_clk);
		start <= 1'b0;
		wait_done();
	endtask
	// Enable low in offset null: nothing may advance until it returns
	task automatic t_freeze;
		@(posedge sys_clk);
		stk <= 1'b0;
		sg <= 1'b1;
		rp <= 8'h10;
		start <= 1'b1;
		@(posedge sys_clk);
		start <= 1'b0;
		ce <= 1'b0;
		repeat (20) @(posedge sys_clk);
		#1;
		`CHK("frozen", 3'h5, {busy, fe_pins.phase_first, fe_pins.phase_second})
		@(posedge sys_clk);
		ce <= 1'b1;
		wait_done();
		`CHK("fz mag", 1'b1, result.magnitude - 24'h00_0010 < 24'h00_0007)
	endtask
	task automatic t_midreset;
		@(posedge sys_clk);
		start <= 1'b1;
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b0;
		start <= 1'b0;
		@(posedge sys_clk) #1;
		`CHK("rst pins", 4'h4, fe_pins)
		`CHK("rst res", 1'b0, result.overrange | busy)
		@(posedge sys_clk);
		reset_n <= 1'b1;
	endtask
	initial
	begin
		repeat (12) @(posedge sys_clk);
		reset_n <= 1'b1;
		t_table();
		t_b2b();
		t_freeze();
		t_midreset();
		t_table();
		finish_test();
	end
	initial
	begin
		#20000;
		mismatches++;
		finish_test();
	end
endmodule
`default_nettype wire
